/* hw/pbt_pkg.sv */
package pbt_pkg;

    // register map, byte addresses
    localparam logic [11:0] ADDR_CFG = 12'h000;
    localparam logic [11:0] ADDR_PROG = 12'h004;
    localparam logic [11:0] ADDR_MAXDUR = 12'h008;
    localparam logic [11:0] ADDR_STEP = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;

    // field positions
    localparam int CFG_DOOR_BIT = 0;
    localparam int CFG_SRST_BIT = 1;
    localparam int PROG_TM_BIT = 0;
    localparam int PROG_ECO_BIT = 1;
    localparam int ST_EN_BIT = 0;
    localparam int ST_LVL_LSB = 1;
    localparam int ST_SEQ_LSB = 3;
    localparam int ST_BUSY_BIT = 5;
    localparam int ST_PEND_LSB = 8;

    // reset values
    localparam logic RST_DOOR_FIT = 1'b0;
    localparam logic RST_BUZ_EN = 1'b1;
    localparam int DUR_W = 10;
    localparam logic [9:0] RST_MAXDUR = 10'h000;
    localparam logic [9:0] RST_STEP = 10'h000;

    // synchronised input positions
    localparam int IX_PWR = 0;
    localparam int IX_END = 1;
    localparam int IX_ALM = 2;
    localparam int IX_SEL = 3;
    localparam int IX_DOOR = 4;
    localparam int IX_PLUS = 5;
    localparam int IX_MINUS = 6;
    localparam int IX_PA = 7;
    localparam int IX_PB = 8;
    localparam int IX_KEYS = 9;

    // pending one-shot requests
    localparam int P_ON = 0;
    localparam int P_OFF = 1;
    localparam int P_CONF = 2;
    localparam int P_CLICK = 3;

    // timing: base tick of one millisecond
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SMS_W = 19;
    localparam logic [18:0] END_INTERVAL_MS = 19'h03A98;
    localparam logic [18:0] END_TOTAL_MS = 19'h1D4C0;
    localparam logic [18:0] ALM_INTERVAL_MS = 19'h03A98;
    localparam logic [18:0] ALM_TOTAL_MS = 19'h493E0;
    localparam logic [11:0] TOGGLE_HOLD_MS = 12'hBB8;
    localparam int BMS_W = 10;
    localparam logic [9:0] CLICK_MS = 10'h014;
    localparam logic [9:0] SHORT_MS = 10'h064;
    localparam logic [9:0] LONG_MS = 10'h1F4;
    localparam logic [9:0] GAP_MS = 10'h096;
    localparam logic [9:0] TUNE_MS = 10'h0C8;

    // tones and levels
    localparam logic [1:0] TONE_CLICK = 2'h0;
    localparam logic [1:0] TONE_LOW = 2'h1;
    localparam logic [1:0] TONE_MID = 2'h2;
    localparam logic [1:0] TONE_HIGH = 2'h3;
    localparam logic [1:0] LVL_MAX = 2'h3;
    localparam logic [1:0] LVL_ECO_STEP = 2'h2;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_END, SEQ_ALARM} pbt_seq_t;
    typedef enum logic [1:0] {B_IDLE, B_ON, B_GAP} pbt_beep_t;

endpackage

/* hw/pbt_beeper.sv */
`timescale 1ns/10ps
`default_nettype none
module pbt_beeper
    import pbt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic tick,
    input wire logic start,
    input wire logic [1:0] count,
    input wire logic [BMS_W-1:0] on_ms,
    input wire logic [BMS_W-1:0] off_ms,
    input wire logic [1:0] tone,
    output logic busy,
    output logic buzz_on,
    output logic [1:0] buzz_tone
);
    pbt_beep_t st_q;
    logic [BMS_W-1:0] ms_q;
    logic [BMS_W-1:0] on_len_q;
    logic [BMS_W-1:0] off_len_q;
    logic [1:0] left_q;
    logic on_end;
    logic gap_end;

    assign on_end = (st_q == B_ON) && tick && (ms_q == on_len_q - 1'b1);
    assign gap_end = (st_q == B_GAP) && tick && (ms_q == off_len_q - 1'b1);
    assign busy = (st_q != B_IDLE);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= B_IDLE;
            ms_q <= '0;
            on_len_q <= '0;
            off_len_q <= '0;
            left_q <= '0;
            buzz_on <= 1'b0;
            buzz_tone <= TONE_CLICK;
        end
        else if (clr)
        begin
            st_q <= B_IDLE;
            buzz_on <= 1'b0;
        end
        else if (start)
        begin
            st_q <= B_ON;
            ms_q <= '0;
            on_len_q <= on_ms;
            off_len_q <= off_ms;
            left_q <= count;
            buzz_on <= 1'b1;
            buzz_tone <= tone;
        end
        else
        begin
            unique case (st_q)
                B_IDLE: ms_q <= '0;
                B_ON:
                begin
                    ms_q <= on_end ? '0 : ms_q + BMS_W'(tick);
                    if (on_end)
                    begin
                        left_q <= left_q - 2'h1;
                        st_q <= (left_q == 2'h1) ? B_IDLE : B_GAP;
                        buzz_on <= 1'b0;
                    end
                end
                B_GAP:
                begin
                    ms_q <= gap_end ? '0 : ms_q + BMS_W'(tick);
                    if (gap_end)
                    begin
                        st_q <= B_ON;
                        buzz_on <= 1'b1;
                    end
                end
                default: st_q <= B_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* hw/pbt_panel_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Switching the appliance on plays one tune and switching it off plays another.
// - Every recognised touch sensor press gives a short click.
// - Cycle end sounds three long beeps, repeated every 15 s until 2 minutes have passed.
// - With the instant door switch fitted, a door opening aborts the cycle-end beeps.
// - A malfunction sounds three short beeps at 15 s intervals for 5 minutes in all.
// - The buzzer enable starts out enabled.
// - When disabled, clicks and malfunction beeps still sound; tunes and cycle-end do not.
// - Enable toggling is taken only in programme selection; alarm beeps never depend on it.
// - Holding the sensor pair for 3 s toggles enable, confirmed by one or two short beeps.
// - Volume is fixed, with no control to adjust it.
// - Selecting a level-capable programme lights all four segments at maximum duration.
// - Plus at four segments changes neither segments nor duration.
// - Outside economy, each minus above the minimum drops one segment and steps the duration down.
// - One segment always stays lit; minus at the minimum changes nothing.
// - Each plus below maximum adds one segment and lengthens the duration up to the maximum.
// - On the economy programme one minus press removes two segments at once, and none when fewer than three are lit.
module pbt_panel_top
    import pbt_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter int unsigned NUM_KEYS = 5
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_on,
    input wire logic cycle_end,
    input wire logic malfunction,
    input wire logic select_phase,
    input wire logic door_open,
    input wire logic key_plus,
    input wire logic key_minus,
    input wire logic pair_key_a,
    input wire logic pair_key_b,
    input wire logic [NUM_KEYS-1:0] touch_key,
    output logic buzz_on,
    output logic [1:0] buzz_tone,
    output logic [3:0] seg_on,
    output logic [DUR_W-1:0] duration
);
    localparam int IN_W = IX_KEYS + NUM_KEYS;
    localparam int TCW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

    logic [IN_W-1:0] raw;
    logic [IN_W-1:0] s1_q;
    logic [IN_W-1:0] s2_q;
    logic [IN_W-1:0] s3_q;
    logic [IN_W-1:0] rise;
    logic [IN_W-1:0] fall;

    assign raw = {touch_key, pair_key_b, pair_key_a, key_minus, key_plus,
                  door_open, select_phase, malfunction, cycle_end, power_on};

    genvar gi;
    generate
        for (gi = 0; gi < IN_W; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                end
                else
                begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                end
            end
        end
    endgenerate

    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;

    // millisecond tick
    logic [TCW-1:0] tick_cnt_q;
    logic tick;
    assign tick = (tick_cnt_q == TCW'(TICK_CYC - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_q <= '0;
        else
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end

    // apb decode
    logic setup;
    logic access;
    logic hit_cfg;
    logic hit_prog;
    logic hit_max;
    logic hit_step;
    logic hit_st;
    logic mapped;
    logic wr_cfg;
    logic wr_prog;
    logic wr_max;
    logic wr_step;
    logic clr;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit_cfg = (paddr == ADDR_CFG);
    assign hit_prog = (paddr == ADDR_PROG);
    assign hit_max = (paddr == ADDR_MAXDUR);
    assign hit_step = (paddr == ADDR_STEP);
    assign hit_st = (paddr == ADDR_STATUS);
    assign mapped = hit_cfg | hit_prog | hit_max | hit_step | hit_st;
    assign wr_cfg = access & pwrite & hit_cfg;
    assign wr_prog = access & pwrite & hit_prog;
    assign wr_max = access & pwrite & hit_max;
    assign wr_step = access & pwrite & hit_step;
    assign clr = wr_cfg & pwdata[CFG_SRST_BIT];
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    logic door_fit_q;
    logic prog_tm_q;
    logic prog_eco_q;
    logic [DUR_W-1:0] maxdur_q;
    logic [DUR_W-1:0] step_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            door_fit_q <= RST_DOOR_FIT;
            prog_tm_q <= 1'b0;
            prog_eco_q <= 1'b0;
            maxdur_q <= RST_MAXDUR;
            step_q <= RST_STEP;
        end
        else
        begin
            if (wr_cfg)
                door_fit_q <= pwdata[CFG_DOOR_BIT];
            if (wr_prog)
            begin
                prog_tm_q <= pwdata[PROG_TM_BIT];
                prog_eco_q <= pwdata[PROG_ECO_BIT];
            end
            if (wr_max)
                maxdur_q <= pwdata[DUR_W-1:0];
            if (wr_step)
                step_q <= pwdata[DUR_W-1:0];
        end
    end

    // buzzer enable and pair-hold toggle
    logic en_q;
    logic [11:0] hold_ms_q;
    logic hold_done_q;
    logic pair_held;
    logic toggle_fire;

    assign pair_held = s2_q[IX_PA] & s2_q[IX_PB] & s2_q[IX_SEL];
    assign toggle_fire = pair_held & ~hold_done_q & tick
                         & (hold_ms_q == TOGGLE_HOLD_MS - 1'b1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_q <= RST_BUZ_EN;
            hold_ms_q <= '0;
            hold_done_q <= 1'b0;
        end
        else if (clr)
        begin
            en_q <= RST_BUZ_EN;
            hold_ms_q <= '0;
            hold_done_q <= 1'b0;
        end
        else if (!pair_held)
        begin
            hold_ms_q <= '0;
            hold_done_q <= 1'b0;
        end
        else if (toggle_fire)
        begin
            en_q <= ~en_q;
            hold_done_q <= 1'b1;
        end
        else if (tick && !hold_done_q)
            hold_ms_q <= hold_ms_q + 12'h001;
    end

    // duration level manager
    logic [1:0] level_q;
    logic [1:0] level_d;
    logic tm_act_d;
    logic eco_d;
    logic [DUR_W-1:0] maxdur_d;
    logic [DUR_W-1:0] step_d;
    logic [DUR_W-1:0] steps_d;
    logic [3:0] seg_d;
    logic [DUR_W-1:0] dur_d;

    assign eco_d = wr_prog ? pwdata[PROG_ECO_BIT] : prog_eco_q;
    assign tm_act_d = eco_d | (wr_prog ? pwdata[PROG_TM_BIT] : prog_tm_q);
    assign maxdur_d = wr_max ? pwdata[DUR_W-1:0] : maxdur_q;
    assign step_d = wr_step ? pwdata[DUR_W-1:0] : step_q;

    always_comb
    begin
        level_d = level_q;
        if (wr_prog)
            level_d = LVL_MAX;
        else if (tm_act_d && rise[IX_PLUS] && level_q != LVL_MAX)
            level_d = level_q + 2'h1;
        else if (tm_act_d && rise[IX_MINUS] && eco_d && level_q >= LVL_ECO_STEP)
            level_d = level_q - LVL_ECO_STEP;
        else if (tm_act_d && rise[IX_MINUS] && !eco_d && level_q != 2'h0)
            level_d = level_q - 2'h1;
    end

    assign steps_d = DUR_W'(LVL_MAX - level_d);
    assign dur_d = tm_act_d ? maxdur_d - steps_d * step_d : maxdur_d;

    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_seg
            assign seg_d[gi] = tm_act_d & (level_d >= 2'(gi));
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level_q <= LVL_MAX;
            seg_on <= 4'h0;
            duration <= RST_MAXDUR;
        end
        else
        begin
            level_q <= level_d;
            seg_on <= seg_d;
            duration <= dur_d;
        end
    end

    // repeating end-of-cycle and alarm sequences
    pbt_seq_t seq_q;
    logic [SMS_W-1:0] seq_ms_q;
    logic [SMS_W-1:0] slot_ms_q;
    logic [SMS_W-1:0] seq_total;
    logic [SMS_W-1:0] seq_interval;
    logic start_alarm;
    logic start_end;
    logic door_abort;
    logic timeout;
    logic slot_wrap;
    logic pat_pend_q;
    logic pat_set;

    assign start_alarm = rise[IX_ALM];
    assign start_end = rise[IX_END] & en_q & (seq_q != SEQ_ALARM);
    assign door_abort = (seq_q == SEQ_END) & rise[IX_DOOR] & door_fit_q;
    assign seq_total = (seq_q == SEQ_ALARM) ? ALM_TOTAL_MS : END_TOTAL_MS;
    assign seq_interval = (seq_q == SEQ_ALARM) ? ALM_INTERVAL_MS : END_INTERVAL_MS;
    assign timeout = (seq_q != SEQ_IDLE) & tick & (seq_ms_q == seq_total - 1'b1);
    assign slot_wrap = (seq_q != SEQ_IDLE) & tick & (slot_ms_q == seq_interval - 1'b1);
    assign pat_set = start_alarm | start_end
                     | (slot_wrap & ~timeout & ~door_abort);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seq_q <= SEQ_IDLE;
            seq_ms_q <= '0;
            slot_ms_q <= '0;
        end
        else if (clr)
            seq_q <= SEQ_IDLE;
        else if (start_alarm || start_end)
        begin
            seq_q <= start_alarm ? SEQ_ALARM : SEQ_END;
            seq_ms_q <= '0;
            slot_ms_q <= '0;
        end
        else if (door_abort || timeout)
            seq_q <= SEQ_IDLE;
        else if (tick && seq_q != SEQ_IDLE)
        begin
            seq_ms_q <= seq_ms_q + 1'b1;
            slot_ms_q <= slot_wrap ? '0 : slot_ms_q + 1'b1;
        end
    end

    // request flags and beeper arbitration
    logic bp_busy;
    logic bp_idle;
    logic g_pat;
    logic [3:0] pend_q;
    logic [3:0] pend_set;
    logic [3:0] grant;
    logic conf_two_q;
    logic pat_play_q;
    logic bp_clr;
    logic bp_start;
    logic [1:0] bp_count;
    logic [BMS_W-1:0] bp_on;
    logic [BMS_W-1:0] bp_off;
    logic [1:0] bp_tone;

    assign bp_idle = ~bp_busy;
    assign g_pat = bp_idle & pat_pend_q;
    assign grant[P_ON] = bp_idle & ~pat_pend_q & pend_q[P_ON];
    assign grant[P_OFF] = bp_idle & ~pat_pend_q & ~pend_q[P_ON] & pend_q[P_OFF];
    assign grant[P_CONF] = bp_idle & ~pat_pend_q & ~(|pend_q[P_OFF:P_ON]) & pend_q[P_CONF];
    assign grant[P_CLICK] = bp_idle & ~pat_pend_q & ~(|pend_q[P_CONF:P_ON]) & pend_q[P_CLICK];
    assign pend_set[P_ON] = rise[IX_PWR] & en_q;
    assign pend_set[P_OFF] = fall[IX_PWR] & en_q;
    assign pend_set[P_CONF] = toggle_fire;
    assign pend_set[P_CLICK] = |rise[IN_W-1:IX_PLUS];
    assign bp_start = g_pat | (|grant);
    // a door abort silences only a pattern group that is sounding
    assign bp_clr = clr | (door_abort & pat_play_q & bp_busy);

    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pend
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    pend_q[gi] <= 1'b0;
                else if (clr)
                    pend_q[gi] <= 1'b0;
                else
                    pend_q[gi] <= pend_set[gi] | (pend_q[gi] & ~grant[gi]);
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pat_pend_q <= 1'b0;
            pat_play_q <= 1'b0;
            conf_two_q <= 1'b0;
        end
        else
        begin
            if (clr)
                pat_pend_q <= 1'b0;
            else if (pat_set)
                pat_pend_q <= 1'b1;
            else if (door_abort || timeout || g_pat)
                pat_pend_q <= 1'b0;
            if (toggle_fire)
                conf_two_q <= en_q;
            if (bp_clr)
                pat_play_q <= 1'b0;
            else if (g_pat)
                pat_play_q <= 1'b1;
            else if (bp_idle)
                pat_play_q <= 1'b0;
        end
    end

    always_comb
    begin
        bp_count = 2'h1;
        bp_on = CLICK_MS;
        bp_off = GAP_MS;
        bp_tone = TONE_CLICK;
        if (g_pat)
        begin
            bp_count = 2'h3;
            bp_on = (seq_q == SEQ_ALARM) ? SHORT_MS : LONG_MS;
            bp_tone = TONE_HIGH;
        end
        else if (grant[P_ON] || grant[P_OFF])
        begin
            bp_count = 2'h2;
            bp_on = TUNE_MS;
            bp_tone = grant[P_ON] ? TONE_HIGH : TONE_LOW;
        end
        else if (grant[P_CONF])
        begin
            bp_count = conf_two_q ? 2'h2 : 2'h1;
            bp_on = SHORT_MS;
            bp_tone = TONE_MID;
        end
    end

    // fixed volume: the buzzer is only ever on or off
    pbt_beeper u_beeper (
        .pclk(pclk),
        .presetn(presetn),
        .clr(bp_clr),
        .tick(tick),
        .start(bp_start),
        .count(bp_count),
        .on_ms(bp_on),
        .off_ms(bp_off),
        .tone(bp_tone),
        .busy(bp_busy),
        .buzz_on(buzz_on),
        .buzz_tone(buzz_tone)
    );

    // register read, data taken in the setup phase
    logic [31:0] rdata_mux;
    assign rdata_mux =
        hit_cfg ? {31'h0, door_fit_q} :
        hit_prog ? {30'h0, prog_eco_q, prog_tm_q} :
        hit_max ? {{(32 - DUR_W){1'b0}}, maxdur_q} :
        hit_step ? {{(32 - DUR_W){1'b0}}, step_q} :
        hit_st ? {20'h0, pend_q, 2'h0, bp_busy, seq_q, level_q, en_q} :
        32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (setup && !pwrite)
            prdata <= rdata_mux;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence prog_sel_s;
        wr_prog && pwdata[PROG_TM_BIT] && !pwdata[PROG_ECO_BIT];
    endsequence
    sequence minus_only_s;
        rise[IX_MINUS] && !rise[IX_PLUS] && !wr_prog && !wr_max && !wr_step;
    endsequence

    en_default_a: assert property (clr |=> en_q)
        else $error("soft reset did not restore enable");
    click_req_a: assert property (rise[IX_PLUS] && !clr |=> pend_q[P_CLICK] || bp_busy)
        else $error("key press gave no click");
    tune_gate_a: assert property (!en_q && !pend_q[P_ON] && !clr |=> !pend_q[P_ON])
        else $error("power tune requested while disabled");
    end_gate_a: assert property (!en_q && seq_q == SEQ_IDLE |=> seq_q != SEQ_END)
        else $error("cycle end pattern while disabled");
    toggle_phase_a: assert property (!s2_q[IX_SEL] && !clr |=> $stable(en_q))
        else $error("enable toggled outside selection");
    door_stop_a: assert property (door_abort && !start_alarm && !clr
        |=> seq_q == SEQ_IDLE && !pat_pend_q)
        else $error("door open did not abort end pattern");
    door_mute_a: assert property (door_abort && pat_play_q && bp_busy |=> !buzz_on)
        else $error("door open left pattern sounding");
    end_hold_a: assert property (seq_q == SEQ_END && !door_abort && !timeout && !clr
        && !start_alarm |=> seq_q == SEQ_END)
        else $error("end pattern stopped by other cause");
    select_full_a: assert property (prog_sel_s |=> seg_on == 4'hF ##0 level_q == LVL_MAX)
        else $error("programme select did not light all segments");
    plus_max_a: assert property (level_q == LVL_MAX && rise[IX_PLUS]
        && !rise[IX_MINUS] && !wr_prog && !wr_max && !wr_step
        |=> $stable(seg_on) && $stable(duration))
        else $error("plus at maximum changed level");
    minus_step_a: assert property (prog_tm_q && !prog_eco_q && level_q != 2'h0
        ##0 minus_only_s |=> level_q == $past(level_q) - 2'h1
        && seg_on == ($past(seg_on) >> 1) && duration == $past(duration) - $past(step_q))
        else $error("minus did not drop one segment");
    min_hold_a: assert property (level_q == 2'h0 ##0 minus_only_s |=> level_q == 2'h0)
        else $error("minus below minimum");
    eco_step_a: assert property (prog_eco_q && level_q == LVL_MAX ##0 minus_only_s
        |=> level_q == LVL_MAX - LVL_ECO_STEP)
        else $error("economy minus did not drop two segments");
    alarm_beep_a: assert property (start_alarm && !clr |=> seq_q == SEQ_ALARM ##0
        pat_pend_q || bp_busy)
        else $error("malfunction pattern not started");
endmodule
`default_nettype wire

/* sim/pbt_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pbt_far_model (
    input wire logic pclk,
    output logic power_on,
    output logic cycle_end,
    output logic malfunction,
    output logic select_phase,
    output logic door_open,
    output logic key_plus,
    output logic key_minus,
    output logic pair_key_a,
    output logic pair_key_b,
    output logic [4:0] touch_key
);
    logic [13:0] pin = 14'h0000;
    assign {touch_key, pair_key_b, pair_key_a, key_minus, key_plus, door_open, select_phase,
        malfunction, cycle_end, power_on} = pin;
    // sensor or status level held for n cycles, then released
    task automatic hold(input logic [13:0] m, input int n);
        @(posedge pclk);
        pin <= pin | m;
        repeat (n) @(posedge pclk);
        pin <= pin & ~m;
    endtask
endmodule
`default_nettype wire

/* sim/panel_buzzer_time_level_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module panel_buzzer_time_level_bench;
    import pbt_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, er, buzz_on, b_q, power_on, cycle_end, malfunction, select_phase;
    logic door_open, key_plus, key_minus, pair_key_a, pair_key_b;
    logic [4:0] touch_key;
    logic [1:0] buzz_tone;
    logic [3:0] seg_on;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [DUR_W-1:0] duration, mx, st;
    logic [13:0] d_q;
    logic [13:0] dq[$];
    logic [1:0] tq[$];
    bit keys[8] = '{1, 0, 0, 0, 0, 1, 1, 1};
    bit watch = 1'b1;
    int err_count = 0, samples_checked = 0, conf = 0, lv = 3, nl;
    always #2.5 pclk = ~pclk;
    pbt_panel_top #(.TICK_CYC(10)) DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .power_on, .cycle_end, .malfunction, .select_phase,
        .door_open, .key_plus, .key_minus, .pair_key_a, .pair_key_b, .touch_key, .buzz_on,
        .buzz_tone, .seg_on, .duration);
    pbt_far_model far (.pclk, .power_on, .cycle_end, .malfunction, .select_phase, .door_open,
        .key_plus, .key_minus, .pair_key_a, .pair_key_b, .touch_key);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [13:0] disp(input int l);
        return {4'((1 << (l + 1)) - 1), mx - 10'(3 - l) * st};
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // oldest note is taken whenever the display changes or, while watch is set, a beep starts
    always @(posedge pclk)
    begin
        b_q <= buzz_on;
        d_q <= {seg_on, duration};
        if (presetn && {seg_on, duration} !== d_q)
            chk({seg_on, duration}, dq.size() ? dq.pop_front() : 'x);
        if (presetn && buzz_on && !b_q && watch)
            chk(buzz_tone, tq.size() ? tq.pop_front() : 'x);
        else if (presetn && buzz_on && !b_q && buzz_tone === TONE_MID)
            conf++;
    end
    initial
    begin
        void'($urandom(32'h1D38));
        wt(5);
        presetn <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[2:0], 3'h7);
        apb(1'b0, 12'h020, 32'h0);
        chk(er, 1'b1);
        st = 10'($urandom_range(60, 1));
        mx = st * 10'h3 + 10'($urandom_range(200, 0));
        apb(1'b1, ADDR_STEP, {22'h0, st});
        dq.push_back({4'h0, mx});
        apb(1'b1, ADDR_MAXDUR, {22'h0, mx});
        dq.push_back({4'hF, mx});
        apb(1'b1, ADDR_PROG, 32'h1);
        foreach (keys[i])
        begin
            nl = keys[i] ? (lv < 3 ? lv + 1 : 3) : (lv > 0 ? lv - 1 : 0);
            if (nl != lv)
                dq.push_back(disp(nl));
            lv = nl;
            tq.push_back(TONE_CLICK);
            far.hold(keys[i] ? 14'h020 : 14'h040, 6);
            wt(400);
        end
        apb(1'b1, ADDR_PROG, 32'h2);
        tq.push_back(TONE_CLICK);
        dq.push_back(disp(1));
        far.hold(14'h040, 6);
        wt(400);
        $display("level test done");
        tq = '{TONE_HIGH, TONE_HIGH, TONE_HIGH};
        far.hold(14'h004, 6);
        wt(9000);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[4:3], 2'h2);
        apb(1'b1, ADDR_CFG, 32'h2);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[4:3], 2'h0);
        tq = '{TONE_HIGH, TONE_HIGH, TONE_LOW, TONE_LOW};
        far.hold(14'h001, 8000);
        wt(8000);
        apb(1'b1, ADDR_CFG, 32'h1);
        tq.push_back(TONE_HIGH);
        far.hold(14'h002, 6);
        wt(2000);
        far.hold(14'h010, 6);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[4:3], 2'h0);
        wt(6000);
        $display("tone test done");
        watch = 1'b0;
        far.hold(14'h188, 30050);
        wt(4500);
        watch = 1'b1;
        chk(conf, 2);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[0], 1'b0);
        far.hold(14'h003, 8000);
        wt(8000);
        tq = '{TONE_CLICK, TONE_HIGH};
        far.hold(14'h200, 6);
        wt(400);
        far.hold(14'h004, 6);
        wt(1500);
        apb(1'b1, ADDR_CFG, 32'h2);
        chk(tq.size() + dq.size(), 0);
        $display("disable test done");
        final_report;
    end
    initial
    begin
        wt(95000);
        err_count++;
        final_report;
    end
endmodule
`default_nettype wire
